// ===== lfr_defines.svh
// register offsets, field positions, reset values and timing counts of the flash ramp controller
`ifndef LFR_DEFINES_SVH
`define LFR_DEFINES_SVH
`define LFR_CLK_MHZ 50
`define LFR_RAMP_UP_NS 12000
`define LFR_RAMP_DN_NS 500
`define LFR_STEP_DLY_US 1000
`define LFR_RAMP_UP_CYC ((`LFR_RAMP_UP_NS * `LFR_CLK_MHZ) / 1000)
`define LFR_RAMP_DN_CYC ((`LFR_RAMP_DN_NS * `LFR_CLK_MHZ) / 1000)
`define LFR_STEP_DLY_CYC (`LFR_STEP_DLY_US * `LFR_CLK_MHZ)
`define LFR_SAFE_CYC 50000
`define LFR_ADDR_CTRL 8'h00
`define LFR_ADDR_FLASH 8'h04
`define LFR_ADDR_VIDEO 8'h08
`define LFR_ADDR_STATUS 8'h0c
`define LFR_ADDR_IRQ_STAT 8'h10
`define LFR_ADDR_IRQ_CLR 8'h14
`define LFR_ADDR_IRQ_EN 8'h18
`define LFR_CTRL_MODE 0
`define LFR_CTRL_VREG 2
`define LFR_CTRL_PSAVE 3
`define LFR_CTRL_DROOP_EN 4
`define LFR_CTRL_INDUCTOR_LIMIT_SELECT 5
`define LFR_CTRL_DROOP_SEL 6
`define LFR_CUR_S13 0
`define LFR_CUR_S2 8
`define LFR_CTRL_RESET 32'h00000000
`define LFR_CUR_RESET 32'h00000000
`define LFR_IRQ_N 5
`define LFR_IRQ_TSD 0
`define LFR_IRQ_DROOP 1
`define LFR_IRQ_UP 2
`define LFR_IRQ_SAFE 3
`define LFR_IRQ_UVLO 4
`endif

// ===== lfr_pkg.sv
// types of the flash ramp controller
package lfr_pkg;
	typedef enum logic [1:0] {
		MODE_OFF = 2'h0,
		MODE_VIDEO = 2'h1,
		MODE_FLASH = 2'h2,
		MODE_VOLT = 2'h3
	} lfr_mode_t;
	typedef enum {
		ST_SHUT,
		ST_PRECHARGE,
		ST_SOFT_LOW,
		ST_SOFT_MID,
		ST_RUN,
		ST_THERMAL
	} lfr_state_t;
	typedef enum logic [1:0] {
		LIM_OFF = 2'h0,
		LIM_25MA = 2'h1,
		LIM_250MA = 2'h2,
		LIM_FULL = 2'h3
	} lfr_limit_t;
endpackage : lfr_pkg

// ===== lfr_tick.sv
// periodic tick from a cycle counter, held at zero while not running
`timescale 1ns/1ps
module lfr_tick #(
	parameter int CYC = 600
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic run,
	output logic tick
);
	localparam int W = $clog2(CYC + 1);
	logic [W-1:0] cnt_r;
	if (CYC < 1) begin : badCyc
		$error("lfr_tick: CYC must be at least 1");
	end
	always_ff @(posedge clk) begin
		if (rst || !run) begin
			cnt_r <= '0;
		end else if (ce) begin
			cnt_r <= (cnt_r == W'(CYC - 1)) ? '0 : cnt_r + 1'b1;
		end
	end
	assign tick = run && ce && (cnt_r == W'(CYC - 1));
endmodule : lfr_tick

// ===== lfr_ramp.sv
// one current sink level, stepped one code toward its target per tick
`timescale 1ns/1ps
module lfr_ramp #(
	parameter int W = 5
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic [W-1:0] target,
	input wire logic upTick,
	input wire logic downTick,
	input wire logic holdUp,
	input wire logic load,
	output logic [W-1:0] level_r
);
	if (W < 1 || W > 8) begin : badW
		$error("lfr_ramp: W must be 1 to 8");
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			level_r <= '0;
		end else if (ce) begin
			if (load) begin
				level_r <= target;
			end else if (level_r < target && upTick && !holdUp) begin
				level_r <= level_r + 1'b1;
			end else if (level_r > target && downTick) begin
				level_r <= level_r - 1'b1;
			end
		end
	end
endmodule : lfr_ramp

// ===== lfr_ctrl.sv
// flash ramp, droop, thermal, current limit and start-up sequencing controller
`include "lfr_defines.svh"
`timescale 1ns/1ps
module lfr_ctrl #(
	parameter int STEP_DLY_CYC = `LFR_STEP_DLY_CYC,
	parameter int SAFE_CYC = `LFR_SAFE_CYC
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic [7:0] addr,
	input wire logic [31:0] wdata,
	input wire logic we,
	input wire logic re,
	output logic [31:0] rdata,
	input wire logic txMask,
	input wire logic downMode,
	input wire logic uvlo,
	input wire logic dieAbove55,
	input wire logic dieAbove70,
	input wire logic dieAbove160,
	input wire logic dieBelow140,
	input wire logic outNearIn,
	input wire logic outAbove3v3,
	input wire logic outInReg,
	input wire logic droopLow,
	output logic [4:0] sinkLevel13,
	output logic [5:0] sinkLevel2,
	output logic droopSample,
	output logic [2:0] droopThreshold,
	output logic switchEn,
	output logic rectifierEn,
	output logic sinksEn,
	output logic [1:0] limitStep,
	output logic limitHigh,
	output logic powerSaveOn,
	output logic balancingEn,
	output logic irq
);
	localparam int SW = $clog2(STEP_DLY_CYC + 1);
	localparam int TW = $clog2(SAFE_CYC + 1);
	if (STEP_DLY_CYC < 1 || SAFE_CYC < 1) begin : badCounts
		$error("lfr_ctrl: counts must be at least 1");
	end

	lfr_pkg::lfr_state_t state_r;
	lfr_pkg::lfr_state_t state_nxt;
	lfr_pkg::lfr_mode_t mode_r;
	logic vregEn_r;
	logic psaveEn_r;
	logic droopEn_r;
	logic ilimReq_r;
	logic ilimAct_r;
	logic [2:0] droopSel_r;
	logic [4:0] flash13_r;
	logic [5:0] flash2_r;
	logic [4:0] video13_r;
	logic [5:0] video2_r;
	logic dieLatch_r;
	logic droopHalt_r;
	logic flashOn_r;
	logic uvlo_r;
	logic [SW-1:0] stepCnt_r;
	logic [TW-1:0] safeCnt_r;
	logic safeExpired;
	logic [`LFR_IRQ_N-1:0] irqStat_r;
	logic [`LFR_IRQ_N-1:0] irqEn_r;
	logic [`LFR_IRQ_N-1:0] irqEvent;
	logic [`LFR_IRQ_N-1:0] irqClr;
	logic [31:0] rdata_r;
	logic [1:0] dieCode;
	logic enabled;
	logic voltMode;
	logic lightMode;
	logic flashing;
	logic blanking;
	logic droopActive;
	logic upTick;
	logic downTick;
	logic [4:0] target13;
	logic [5:0] target2;
	logic wrCtrl;
	logic rdStatus;

	assign wrCtrl = we && addr == `LFR_ADDR_CTRL;
	assign rdStatus = re && addr == `LFR_ADDR_STATUS;
	assign voltMode = vregEn_r || mode_r == lfr_pkg::MODE_VOLT;
	assign lightMode = mode_r == lfr_pkg::MODE_VIDEO || mode_r == lfr_pkg::MODE_FLASH;
	assign enabled = vregEn_r || mode_r != lfr_pkg::MODE_OFF;
	assign flashing = state_r == lfr_pkg::ST_RUN && mode_r == lfr_pkg::MODE_FLASH;
	assign blanking = flashing && txMask;
	// monitor sits out while disabled or while blanking pulls current down anyway
	assign droopActive = droopEn_r && !txMask;

	// software fields; hardware clears of the mode win over a same-cycle write
	always_ff @(posedge clk) begin
		if (rst) begin
			mode_r <= lfr_pkg::MODE_OFF;
			vregEn_r <= 1'b0;
			psaveEn_r <= 1'b0;
			droopEn_r <= 1'b0;
			ilimReq_r <= 1'b0;
			droopSel_r <= 3'h0;
		end else if (ce) begin
			if (wrCtrl) begin
				mode_r <= lfr_pkg::lfr_mode_t'(wdata[`LFR_CTRL_MODE +: 2]);
				vregEn_r <= wdata[`LFR_CTRL_VREG];
				psaveEn_r <= wdata[`LFR_CTRL_PSAVE];
				droopEn_r <= wdata[`LFR_CTRL_DROOP_EN];
				ilimReq_r <= wdata[`LFR_CTRL_INDUCTOR_LIMIT_SELECT];
				droopSel_r <= wdata[`LFR_CTRL_DROOP_SEL +: 3];
			end
			if ((dieAbove160 && lightMode) || safeExpired) begin
				mode_r <= lfr_pkg::MODE_OFF;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			flash13_r <= 5'h00;
			flash2_r <= 6'h00;
			video13_r <= 5'h00;
			video2_r <= 6'h00;
		end else if (ce) begin
			if (we && addr == `LFR_ADDR_FLASH) begin
				flash13_r <= wdata[`LFR_CUR_S13 +: 5];
				flash2_r <= wdata[`LFR_CUR_S2 +: 6];
			end
			if (we && addr == `LFR_ADDR_VIDEO) begin
				video13_r <= wdata[`LFR_CUR_S13 +: 5];
				video2_r <= wdata[`LFR_CUR_S2 +: 6];
			end
		end
	end

	// limit select is frozen once the converter has left shutdown
	always_ff @(posedge clk) begin
		if (rst) begin
			ilimAct_r <= 1'b0;
		end else if (ce && wrCtrl && state_r == lfr_pkg::ST_SHUT) begin
			ilimAct_r <= wdata[`LFR_CTRL_INDUCTOR_LIMIT_SELECT];
		end
	end

	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			lfr_pkg::ST_SHUT: begin
				if (enabled && !uvlo) begin
					state_nxt = lfr_pkg::ST_PRECHARGE;
				end
			end
			lfr_pkg::ST_PRECHARGE: begin
				if (outNearIn || outAbove3v3) begin
					state_nxt = lfr_pkg::ST_SOFT_LOW;
				end
			end
			lfr_pkg::ST_SOFT_LOW: begin
				if (stepCnt_r == SW'(STEP_DLY_CYC - 1)) begin
					state_nxt = lfr_pkg::ST_SOFT_MID;
				end
			end
			lfr_pkg::ST_SOFT_MID: begin
				if (outInReg) begin
					state_nxt = lfr_pkg::ST_RUN;
				end
			end
			lfr_pkg::ST_RUN: begin
			end
			lfr_pkg::ST_THERMAL: begin
				if (voltMode && dieBelow140 && !dieAbove160) begin
					state_nxt = lfr_pkg::ST_PRECHARGE;
				end
			end
		endcase
		if (dieAbove160 && state_r != lfr_pkg::ST_SHUT) begin
			state_nxt = lfr_pkg::ST_THERMAL;
		end
		if (!enabled) begin
			state_nxt = lfr_pkg::ST_SHUT;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state_r <= lfr_pkg::ST_SHUT;
		end else if (ce) begin
			state_r <= state_nxt;
		end
	end

	always_ff @(posedge clk) begin
		if (rst || state_r != lfr_pkg::ST_SOFT_LOW) begin
			stepCnt_r <= '0;
		end else if (ce) begin
			stepCnt_r <= stepCnt_r + 1'b1;
		end
	end

	// safety timer runs on flash alone, blanking does not pause or restart it
	always_ff @(posedge clk) begin
		if (rst || !flashing) begin
			safeCnt_r <= '0;
		end else if (ce && !safeExpired) begin
			safeCnt_r <= safeCnt_r + 1'b1;
		end
	end
	assign safeExpired = flashing && safeCnt_r == TW'(SAFE_CYC - 1);

	// battery sample strobe and threshold at the first cycle of a flash
	always_ff @(posedge clk) begin
		if (rst) begin
			flashOn_r <= 1'b0;
		end else if (ce) begin
			flashOn_r <= flashing;
		end
	end
	assign droopSample = ce && flashing && !flashOn_r && droopEn_r;

	always_ff @(posedge clk) begin
		if (rst) begin
			droopThreshold <= 3'h0;
		end else if (ce && flashing && !flashOn_r) begin
			droopThreshold <= droopSel_r;
		end
	end

	// once tripped the ramp stays held for the rest of this flash
	always_ff @(posedge clk) begin
		if (rst || !flashing) begin
			droopHalt_r <= 1'b0;
		end else if (ce && droopActive && droopLow && sinkLevel13 < target13) begin
			droopHalt_r <= 1'b1;
		end
	end

	always_comb begin
		target13 = 5'h00;
		target2 = 6'h00;
		if (state_r == lfr_pkg::ST_RUN && mode_r == lfr_pkg::MODE_VIDEO) begin
			target13 = video13_r;
			target2 = video2_r;
		end else if (flashing && !txMask) begin
			target13 = flash13_r;
			target2 = flash2_r;
		end else if (blanking) begin
			target13 = video13_r;
			target2 = video2_r;
		end
	end

	lfr_tick #(
		.CYC(`LFR_RAMP_UP_CYC)
	) upTimer (
		.clk(clk),
		.rst(rst),
		.ce(ce),
		.run(state_r == lfr_pkg::ST_RUN),
		.tick(upTick)
	);

	lfr_tick #(
		.CYC(`LFR_RAMP_DN_CYC)
	) downTimer (
		.clk(clk),
		.rst(rst),
		.ce(ce),
		.run(1'b1),
		.tick(downTick)
	);

	// blanking loads the lower level directly; leaving a light mode or a trip zeroes at once
	lfr_ramp #(
		.W(5)
	) ramp13 (
		.clk(clk),
		.rst(rst),
		.ce(ce),
		.target(target13),
		.upTick(upTick),
		.downTick(downTick),
		.holdUp(droopHalt_r || (droopActive && droopLow && flashing)),
		.load((blanking && sinkLevel13 > target13) || !sinksEn),
		.level_r(sinkLevel13)
	);

	lfr_ramp #(
		.W(6)
	) ramp2 (
		.clk(clk),
		.rst(rst),
		.ce(ce),
		.target(target2),
		.upTick(upTick),
		.downTick(downTick),
		.holdUp(droopHalt_r || (droopActive && droopLow && flashing)),
		.load((blanking && sinkLevel2 > target2) || !sinksEn),
		.level_r(sinkLevel2)
	);

	// trip code latched until status is read; the trip wins over a same-cycle read
	always_ff @(posedge clk) begin
		if (rst) begin
			dieLatch_r <= 1'b0;
		end else if (ce) begin
			if (dieAbove160 && state_r != lfr_pkg::ST_SHUT) begin
				dieLatch_r <= 1'b1;
			end else if (rdStatus) begin
				dieLatch_r <= 1'b0;
			end
		end
	end

	always_comb begin
		dieCode = 2'h0;
		if (dieLatch_r) begin
			dieCode = 2'h3;
		end else if (state_r == lfr_pkg::ST_SHUT) begin
			dieCode = 2'h0;
		end else if (dieAbove70) begin
			dieCode = 2'h2;
		end else if (dieAbove55) begin
			dieCode = 2'h1;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			uvlo_r <= 1'b0;
		end else if (ce) begin
			uvlo_r <= uvlo;
		end
	end

	always_comb begin
		irqEvent = '0;
		irqEvent[`LFR_IRQ_TSD] = ce && dieAbove160 && state_r != lfr_pkg::ST_SHUT && !dieLatch_r;
		irqEvent[`LFR_IRQ_DROOP] = ce && flashing && !droopHalt_r && droopActive && droopLow;
		irqEvent[`LFR_IRQ_UP] = ce && state_r == lfr_pkg::ST_SOFT_MID && state_nxt == lfr_pkg::ST_RUN;
		irqEvent[`LFR_IRQ_SAFE] = ce && safeExpired;
		irqEvent[`LFR_IRQ_UVLO] = ce && uvlo && !uvlo_r;
	end
	assign irqClr = (ce && we && addr == `LFR_ADDR_IRQ_CLR) ? wdata[`LFR_IRQ_N-1:0] : '0;

	// set wins over clear so no event is lost
	always_ff @(posedge clk) begin
		if (rst) begin
			irqStat_r <= '0;
			irqEn_r <= '0;
		end else if (ce) begin
			irqStat_r <= (irqStat_r & ~irqClr) | irqEvent;
			if (we && addr == `LFR_ADDR_IRQ_EN) begin
				irqEn_r <= wdata[`LFR_IRQ_N-1:0];
			end
		end
	end
	assign irq = |(irqStat_r & irqEn_r);

	always_ff @(posedge clk) begin
		if (rst) begin
			rdata_r <= 32'h00000000;
		end else if (ce) begin
			rdata_r <= 32'h00000000;
			if (re) begin
				unique case (addr)
					`LFR_ADDR_CTRL: begin
						rdata_r <= {23'h000000, droopSel_r, ilimReq_r, droopEn_r, psaveEn_r, vregEn_r, mode_r};
					end
					`LFR_ADDR_FLASH: begin
						rdata_r <= {18'h00000, flash2_r, 3'h0, flash13_r};
					end
					`LFR_ADDR_VIDEO: begin
						rdata_r <= {18'h00000, video2_r, 3'h0, video13_r};
					end
					`LFR_ADDR_STATUS: begin
						rdata_r <= {25'h0000000, ilimAct_r, droopHalt_r, limitStep, uvlo, dieCode};
					end
					`LFR_ADDR_IRQ_STAT: begin
						rdata_r <= {27'h0000000, irqStat_r};
					end
					`LFR_ADDR_IRQ_EN: begin
						rdata_r <= {27'h0000000, irqEn_r};
					end
					default: begin
						rdata_r <= 32'h00000000;
					end
				endcase
			end
		end
	end
	assign rdata = rdata_r;

	// switching stages gated by undervoltage so a low battery never turns them on
	always_comb begin
		switchEn = !uvlo && (state_r == lfr_pkg::ST_SOFT_LOW || state_r == lfr_pkg::ST_SOFT_MID ||
			state_r == lfr_pkg::ST_RUN);
		rectifierEn = !uvlo && state_r != lfr_pkg::ST_SHUT && state_r != lfr_pkg::ST_THERMAL;
		sinksEn = state_r == lfr_pkg::ST_RUN && lightMode;
		unique case (state_r)
			lfr_pkg::ST_SOFT_LOW: limitStep = lfr_pkg::LIM_25MA;
			lfr_pkg::ST_SOFT_MID: limitStep = lfr_pkg::LIM_250MA;
			lfr_pkg::ST_RUN: limitStep = lfr_pkg::LIM_FULL;
			default: limitStep = lfr_pkg::LIM_OFF;
		endcase
		limitHigh = ilimAct_r;
		powerSaveOn = downMode || psaveEn_r;
		balancingEn = state_r == lfr_pkg::ST_PRECHARGE || state_r == lfr_pkg::ST_SOFT_LOW ||
			state_r == lfr_pkg::ST_SOFT_MID;
	end
endmodule : lfr_ctrl

// ===== lfr_ctrl_asserts.sv
// port checker of the flash ramp controller, bound to its top module
`timescale 1ns/1ps
module lfr_ctrl_chk #(
	parameter int STEP_DLY_CYC = 20,
	parameter int SAFE_CYC = 4000
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic [7:0] addr,
	input wire logic [31:0] wdata,
	input wire logic we,
	input wire logic re,
	input wire logic [31:0] rdata,
	input wire logic txMask,
	input wire logic downMode,
	input wire logic uvlo,
	input wire logic dieAbove55,
	input wire logic dieAbove70,
	input wire logic dieAbove160,
	input wire logic dieBelow140,
	input wire logic outNearIn,
	input wire logic outAbove3v3,
	input wire logic outInReg,
	input wire logic droopLow,
	input wire logic [4:0] sinkLevel13,
	input wire logic [5:0] sinkLevel2,
	input wire logic droopSample,
	input wire logic [2:0] droopThreshold,
	input wire logic switchEn,
	input wire logic rectifierEn,
	input wire logic sinksEn,
	input wire logic [1:0] limitStep,
	input wire logic limitHigh,
	input wire logic powerSaveOn,
	input wire logic balancingEn,
	input wire logic irq
);
	int lowCnt_r;
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	// cycles spent at the lowest soft-start limit
	always_ff @(posedge clk) begin
		if (rst || limitStep != 2'h1) begin
			lowCnt_r <= 0;
		end else begin
			lowCnt_r <= lowCnt_r + 1;
		end
	end
	precharge_first_a: assert property ($rose(switchEn) |-> $past(rectifierEn))
		else $error("switching began without precharge");
	// rectifier follows the live flag, so it may rise in the very cycle the flag drops
	uvlo_block_a: assert property ($rose(rectifierEn) |-> !uvlo)
		else $error("stage turned on under undervoltage");
	thermal_off_a: assert property (dieAbove160 && switchEn |=> !switchEn && !sinksEn)
		else $error("stage still on after thermal trip");
	save_forced_a: assert property (downMode |-> powerSaveOn)
		else $error("power save off in down mode");
	balance_off_a: assert property (limitStep == 2'h3 |-> !balancingEn)
		else $error("balancing on at full limit");
	limit_order_a: assert property (limitStep > $past(limitStep) |-> limitStep == $past(limitStep) + 2'h1)
		else $error("limit step skipped");
	step_delay_a: assert property (limitStep == 2'h2 && $past(limitStep) == 2'h1 |->
		lowCnt_r >= STEP_DLY_CYC - 1 && lowCnt_r <= STEP_DLY_CYC + 1)
		else $error("low limit held for wrong time");
	step_size_a: assert property (sinksEn && $past(sinksEn) && !$past(txMask) && sinkLevel13 != $past(sinkLevel13)
		|-> sinkLevel13 - $past(sinkLevel13) == 5'h1 || $past(sinkLevel13) - sinkLevel13 == 5'h1)
		else $error("sink level moved more than one code");
	up_gap_a: assert property (sinkLevel13 > $past(sinkLevel13) && !txMask |=> (sinkLevel13 <= $past(sinkLevel13)) [*8])
		else $error("ramp up steps too close");
	sample_once_a: assert property (droopSample |=> !droopSample [*8])
		else $error("battery sampled more than once");
	cover property (limitStep == 2'h3);
	cover property (droopSample);
	cover property (txMask && sinksEn);
	cover property (irq);
endmodule : lfr_ctrl_chk
bind lfr_ctrl lfr_ctrl_chk #(.STEP_DLY_CYC(STEP_DLY_CYC), .SAFE_CYC(SAFE_CYC)) u_chk (.clk(clk), .rst(rst), .ce(ce),
	.addr(addr), .wdata(wdata), .we(we), .re(re), .rdata(rdata), .txMask(txMask), .downMode(downMode), .uvlo(uvlo),
	.dieAbove55(dieAbove55), .dieAbove70(dieAbove70), .dieAbove160(dieAbove160), .dieBelow140(dieBelow140),
	.outNearIn(outNearIn), .outAbove3v3(outAbove3v3), .outInReg(outInReg), .droopLow(droopLow),
	.sinkLevel13(sinkLevel13), .sinkLevel2(sinkLevel2), .droopSample(droopSample), .droopThreshold(droopThreshold),
	.switchEn(switchEn), .rectifierEn(rectifierEn), .sinksEn(sinksEn), .limitStep(limitStep),
	.limitHigh(limitHigh), .powerSaveOn(powerSaveOn), .balancingEn(balancingEn), .irq(irq));

// ===== lfr_far_model.sv
// output stage plant seen by the controller: pre-charge and regulation indications
`timescale 1ns/1ps
module lfr_far_model #(
	parameter int CHG_CYC = 6,
	parameter int REG_CYC = 40
) (
	input wire logic clk,
	input wire logic rectifierEn,
	input wire logic switchEn,
	input wire logic slow,
	output logic outNearIn,
	output logic outAbove3v3,
	output logic outInReg
);
	int chgCnt_r = 0;
	int regCnt_r = 0;
	always_ff @(posedge clk) begin
		chgCnt_r <= rectifierEn ? chgCnt_r + 1 : 0;
		regCnt_r <= switchEn ? regCnt_r + 1 : 0;
	end
	// slow case: a high input is never reached, so 3.3 V ends pre-charge
	assign outNearIn = !slow && chgCnt_r >= CHG_CYC;
	assign outAbove3v3 = slow && chgCnt_r >= 3 * CHG_CYC;
	// regulation comes well after the 250 mA step so every limit step is seen
	assign outInReg = regCnt_r >= REG_CYC;
endmodule : lfr_far_model

// ===== tb_lfr_ctrl.sv
// self-checking bench of the flash ramp controller
`timescale 1ns/1ps
module tb_lfr_ctrl;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic we = 1'b0;
	logic re = 1'b0;
	logic txMask = 1'b0;
	logic downMode = 1'b0;
	logic uvlo = 1'b0;
	logic dieAbove55 = 1'b0;
	logic dieAbove70 = 1'b0;
	logic dieAbove160 = 1'b0;
	logic dieBelow140 = 1'b0;
	logic droopLow = 1'b0;
	logic slow = 1'b0;
	logic outNearIn, outAbove3v3, outInReg, droopSample, switchEn, rectifierEn, sinksEn;
	logic limitHigh, powerSaveOn, balancingEn, irq;
	logic [31:0] rdata;
	logic [31:0] rd;
	logic [4:0] sinkLevel13;
	logic [5:0] sinkLevel2;
	logic [2:0] droopThreshold;
	logic [1:0] limitStep;
	int fail_count = 0;
	int n_tests = 0;
	int n;
	always #10 clk = ~clk;
	// short soft-start delay keeps the run brief; safety timeout outlasts a full ramp
	lfr_ctrl #(.STEP_DLY_CYC(20), .SAFE_CYC(4000)) u_dut (.clk(clk), .rst(rst), .ce(1'b1), .addr(addr),
		.wdata(wdata), .we(we), .re(re), .rdata(rdata), .txMask(txMask), .downMode(downMode), .uvlo(uvlo),
		.dieAbove55(dieAbove55), .dieAbove70(dieAbove70), .dieAbove160(dieAbove160), .dieBelow140(dieBelow140),
		.outNearIn(outNearIn), .outAbove3v3(outAbove3v3), .outInReg(outInReg), .droopLow(droopLow),
		.sinkLevel13(sinkLevel13), .sinkLevel2(sinkLevel2), .droopSample(droopSample),
		.droopThreshold(droopThreshold), .switchEn(switchEn), .rectifierEn(rectifierEn), .sinksEn(sinksEn),
		.limitStep(limitStep), .limitHigh(limitHigh), .powerSaveOn(powerSaveOn), .balancingEn(balancingEn), .irq(irq));
	lfr_far_model u_far (.clk(clk), .rectifierEn(rectifierEn), .switchEn(switchEn), .slow(slow),
		.outNearIn(outNearIn), .outAbove3v3(outAbove3v3), .outInReg(outInReg));
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e) begin
			fail_count++;
			$display("BAD %0t got %h want %h", $time, g, e);
		end
	endtask : chk
	task automatic chkb(input logic g, input logic e);
		chk({31'h0, g}, {31'h0, e});
	endtask : chkb
	task automatic cyc(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask : cyc
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		we <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		we <= 1'b0;
	endtask : wr
	task automatic rdr(input logic [7:0] a);
		@(posedge clk);
		re <= 1'b1;
		addr <= a;
		@(posedge clk);
		re <= 1'b0;
		#1;
		rd = rdata;
	endtask : rdr
	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		rdr(a);
		chk(rd, e);
	endtask : rdc
	task automatic wait_lvl(input logic [4:0] v);
		n = 0;
		while (sinkLevel13 !== v && n < 3000) begin
			cyc(1);
			n++;
		end
	endtask : wait_lvl
	task automatic wait_lim(input logic [1:0] v);
		n = 0;
		while (limitStep !== v && n < 300) begin
			cyc(1);
			n++;
		end
		chkb(limitStep == v, 1'b1);
	endtask : wait_lim
	task automatic finish_test;
		$display("comparisons %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : finish_test
	// whole sequence needs about 9000 cycles
	initial begin
		#(20 * 40000);
		fail_count++;
		finish_test();
	end
	initial begin
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		dieAbove55 <= 1'b1;
		downMode <= 1'b1;
		rdc(8'h0c, 32'h0);
		rdc(8'h1c, 32'h0);
		chkb(powerSaveOn, 1'b1);
		@(posedge clk);
		downMode <= 1'b0;
		uvlo <= 1'b1;
		wr(8'h00, 32'h20);
		cyc(1);
		chkb(limitHigh, 1'b1);
		chkb(powerSaveOn, 1'b0);
		wr(8'h04, 32'h0604);
		wr(8'h08, 32'h0302);
		wr(8'h00, 32'h24);
		cyc(10);
		chkb(rectifierEn, 1'b0);
		@(posedge clk);
		uvlo <= 1'b0;
		wr(8'h14, 32'h1f);
		wait_lim(2'h1);
		chkb(switchEn, 1'b1);
		wait_lim(2'h2);
		chkb(n >= 19 && n <= 21, 1'b1);
		wait_lim(2'h3);
		chkb(balancingEn, 1'b0);
		chkb(irq, 1'b0);
		rdc(8'h10, 32'h4);
		wr(8'h18, 32'h4);
		cyc(1);
		chkb(irq, 1'b1);
		wr(8'h14, 32'h4);
		cyc(1);
		chkb(irq, 1'b0);
		// limit bit written while running is kept but not applied
		wr(8'h00, 32'h04);
		cyc(1);
		chkb(limitHigh, 1'b1);
		for (int i = 0; i < 3; i++) begin
			@(posedge clk);
			dieAbove55 <= i > 0;
			dieAbove70 <= i > 1;
			rdc(8'h0c, 32'h58 | 32'(i));
		end
		@(posedge clk);
		dieAbove160 <= 1'b1;
		cyc(2);
		chkb(switchEn, 1'b0);
		chkb(sinksEn, 1'b0);
		@(posedge clk);
		dieAbove160 <= 1'b0;
		rdc(8'h0c, 32'h43);
		rdc(8'h0c, 32'h42);
		@(posedge clk);
		slow <= 1'b1;
		dieBelow140 <= 1'b1;
		wait_lim(2'h3);
		@(posedge clk);
		dieBelow140 <= 1'b0;
		wr(8'h00, 32'h06);
		wait_lvl(5'h1);
		wait_lvl(5'h2);
		chk(n, 600);
		wait_lvl(5'h4);
		@(posedge clk);
		txMask <= 1'b1;
		cyc(1);
		chk({27'h0, sinkLevel13}, 32'h2);
		chk({26'h0, sinkLevel2}, 32'h3);
		wr(8'h04, 32'h0);
		@(posedge clk);
		txMask <= 1'b0;
		wait_lvl(5'h1);
		wait_lvl(5'h0);
		chk(n, 25);
		wr(8'h00, 32'h04);
		wr(8'h04, 32'h0604);
		wr(8'h00, 32'h156);
		cyc(0);
		chkb(droopSample, 1'b1);
		// threshold is registered on the first flash cycle, so it shows one edge later
		cyc(1);
		chk({29'h0, droopThreshold}, 32'h5);
		wait_lvl(5'h1);
		@(posedge clk);
		droopLow <= 1'b1;
		cyc(700);
		chk({27'h0, sinkLevel13}, 32'h1);
		rdr(8'h10);
		chkb(rd[1], 1'b1);
		wr(8'h00, 32'h04);
		wr(8'h00, 32'h146);
		wait_lvl(5'h2);
		chk({27'h0, sinkLevel13}, 32'h2);
		wr(8'h00, 32'h04);
		@(posedge clk);
		droopLow <= 1'b0;
		txMask <= 1'b1;
		wr(8'h00, 32'h06);
		cyc(1000);
		@(posedge clk);
		txMask <= 1'b0;
		n = 1001;
		while (sinksEn === 1'b1 && n < 6000) begin
			cyc(1);
			n++;
		end
		chkb(n >= 3990 && n <= 4010, 1'b1);
		chkb(switchEn, 1'b1);
		wr(8'h00, 32'h00);
		cyc(1);
		chkb(switchEn, 1'b0);
		rdc(8'h0c, 32'h40);
		finish_test();
	end
endmodule : tb_lfr_ctrl
